// ===== design/dual_pll_divider_config_regs.sv
// Three-wire serial configuration store for two synthesizer loops
`timescale 1ns/1ps
module dual_pll_divider_config_regs
	import synth_cfg_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic latch_strobe,
	output logic [RATIO_W-1:0] secondary_ref_ratio,
	output logic secondary_detector_sense,
	output logic secondary_pump_boost,
	output logic secondary_pump_float,
	output logic [PIN_SEL_W-1:0] secondary_pin_sel,
	output logic [RATIO_W-1:0] primary_ref_ratio,
	output logic primary_detector_sense,
	output logic primary_pump_boost,
	output logic primary_pump_float,
	output logic [PIN_SEL_W-1:0] primary_pin_sel,
	output logic [SWALLOW_W-1:0] secondary_swallow_count,
	output logic [PROGRAM_W-1:0] secondary_program_count,
	output logic secondary_modulus_sel,
	output logic secondary_shutdown_bit,
	output logic [SWALLOW_W-1:0] primary_swallow_count,
	output logic [PROGRAM_W-1:0] primary_program_count,
	output logic primary_modulus_sel,
	output logic primary_shutdown_bit
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic sclk_rise;
	logic strobe_rise;
	logic data_meta_q;
	logic data_sync_q;

	edge_sync u_sclk (
		.clk(clk),
		.rstn(rstn),
		.pin(serial_clk),
		.level(),
		.rise(sclk_rise)
	);

	edge_sync u_strobe (
		.clk(clk),
		.rstn(rstn),
		.pin(latch_strobe),
		.level(),
		.rise(strobe_rise)
	);

	// Data takes the same two stages as the clock so both stay aligned
	always_ff @(posedge clk) begin
		if (!rstn) begin
			data_meta_q <= 1'h0;
			data_sync_q <= 1'h0;
		end else begin
			data_meta_q <= serial_data;
			data_sync_q <= data_meta_q;
		end
	end

	// ----------------------------------------
	// Holding register
	// ----------------------------------------
	logic [WORD_W-1:0] shift_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			shift_q <= SHIFT_RESET;
		end else if (sclk_rise) begin
			shift_q <= {shift_q[WORD_W-2:0], data_sync_q};
		end
	end

	// ----------------------------------------
	// Latch decode
	// ----------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] sel, input logic [ADDR_W-1:0] code);
		hit = (sel == code);
	endfunction

	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data;
	logic [DATA_W-1:0] sec_ref_q;
	logic [DATA_W-1:0] sec_fb_q;
	logic [DATA_W-1:0] pri_ref_q;
	logic [DATA_W-1:0] pri_fb_q;

	assign addr = shift_q[ADDR_W-1:0];
	assign data = shift_q[WORD_W-1:DATA_LSB];

	// Reset loads WORD_RESET (all zeros) into each word; the host must program each word before use
	always_ff @(posedge clk) begin
		if (!rstn) begin
			sec_ref_q <= WORD_RESET;
		end else if (strobe_rise && hit(addr, ADDR_SEC_REF)) begin
			sec_ref_q <= data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pri_ref_q <= WORD_RESET;
		end else if (strobe_rise && hit(addr, ADDR_PRI_REF)) begin
			pri_ref_q <= data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sec_fb_q <= WORD_RESET;
		end else if (strobe_rise && hit(addr, ADDR_SEC_FB)) begin
			sec_fb_q <= data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			pri_fb_q <= WORD_RESET;
		end else if (strobe_rise && hit(addr, ADDR_PRI_FB)) begin
			pri_fb_q <= data;
		end
	end

	// ----------------------------------------
	// Field outputs
	// ----------------------------------------
	// Ratio passes straight through; values below 2 are the host's fault
	assign secondary_ref_ratio = sec_ref_q[RATIO_LSB +: RATIO_W];
	assign primary_ref_ratio = pri_ref_q[RATIO_LSB +: RATIO_W];
	assign secondary_detector_sense = sec_ref_q[DET_SENSE_BIT];
	assign secondary_pump_boost = sec_ref_q[PUMP_BOOST_BIT];
	assign secondary_pump_float = sec_ref_q[PUMP_FLOAT_BIT];
	assign secondary_pin_sel = sec_ref_q[PIN_SEL_LSB +: PIN_SEL_W];
	assign primary_detector_sense = pri_ref_q[DET_SENSE_BIT];
	assign primary_pump_boost = pri_ref_q[PUMP_BOOST_BIT];
	assign primary_pump_float = pri_ref_q[PUMP_FLOAT_BIT];
	assign primary_pin_sel = pri_ref_q[PIN_SEL_LSB +: PIN_SEL_W];
	assign secondary_swallow_count = sec_fb_q[SWALLOW_LSB +: SWALLOW_W];
	assign secondary_program_count = sec_fb_q[PROGRAM_LSB +: PROGRAM_W];
	assign secondary_modulus_sel = sec_fb_q[MODULUS_BIT];
	assign secondary_shutdown_bit = sec_fb_q[SHUTDOWN_BIT];
	assign primary_swallow_count = pri_fb_q[SWALLOW_LSB +: SWALLOW_W];
	assign primary_program_count = pri_fb_q[PROGRAM_LSB +: PROGRAM_W];
	assign primary_modulus_sel = pri_fb_q[MODULUS_BIT];
	assign primary_shutdown_bit = pri_fb_q[SHUTDOWN_BIT];

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_strobe_to(logic [1:0] code);
		strobe_rise && addr == code;
	endsequence

	a_shift_msb_first: assert property (@(posedge clk) disable iff (!rstn)
		sclk_rise |=> shift_q[0] == $past(data_sync_q) && shift_q[WORD_W-1:1] == $past(shift_q[WORD_W-2:0]))
		else $error("holding register did not shift");

	a_sec_ref_load: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_SEC_REF) |=> sec_ref_q == $past(data))
		else $error("secondary reference not loaded");

	a_pri_ref_load: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_PRI_REF) |=> pri_ref_q == $past(data))
		else $error("primary reference not loaded");

	a_sec_fb_load: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_SEC_FB) |=> sec_fb_q == $past(data))
		else $error("secondary feedback not loaded");

	a_pri_fb_load: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_PRI_FB) |=> pri_fb_q == $past(data))
		else $error("primary feedback not loaded");

	a_ratio_field: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_PRI_REF) |=> primary_ref_ratio == $past(shift_q[16:2]))
		else $error("primary ratio field misplaced");

	a_fb_fields: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_SEC_FB) |=> secondary_swallow_count == $past(shift_q[6:2])
			&& secondary_program_count == $past(shift_q[19:7]) && secondary_shutdown_bit == $past(shift_q[21]))
		else $error("secondary feedback fields misplaced");

	a_hold_no_strobe: assert property (@(posedge clk) disable iff (!rstn)
		!strobe_rise |=> $stable(sec_ref_q) && $stable(sec_fb_q) && $stable(pri_ref_q) && $stable(pri_fb_q))
		else $error("latch changed without strobe");

	a_hold_other_addr: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_PRI_FB) |=> $stable(sec_ref_q) && $stable(sec_fb_q) && $stable(pri_ref_q))
		else $error("unaddressed latch changed");

	// ----------------------------------------
	// Assertions: field layout
	// ----------------------------------------
	// Bit positions are spelled out here so a slip in the package constants cannot hide
	a_sec_ratio_field: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_SEC_REF) |=> secondary_ref_ratio == $past(shift_q[16:2]))
		else $error("secondary ratio field misplaced");

	a_pri_ratio_layout: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_PRI_REF) |=> primary_ref_ratio == $past(data[14:0]))
		else $error("primary ratio layout differs from secondary");

	a_ratio_unsigned: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_SEC_REF) |=> 32'(secondary_ref_ratio) == $past(32'(data) % 32'h00008000))
		else $error("secondary ratio is not the plain low field");

	a_sec_mode_bits: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_SEC_REF) |=> secondary_detector_sense == $past(shift_q[17])
			&& secondary_pump_boost == $past(shift_q[18]) && secondary_pump_float == $past(shift_q[19])
			&& secondary_pin_sel == $past(shift_q[21:20]))
		else $error("secondary mode bits misplaced");

	a_pri_mode_bits: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_PRI_REF) |=> primary_detector_sense == $past(shift_q[17])
			&& primary_pump_boost == $past(shift_q[18]) && primary_pump_float == $past(shift_q[19])
			&& primary_pin_sel == $past(shift_q[21:20]))
		else $error("primary mode bits misplaced");

	a_sec_fb_modulus: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_SEC_FB) |=> secondary_modulus_sel == $past(shift_q[20])
			&& secondary_shutdown_bit == $past(shift_q[21]))
		else $error("secondary modulus or shutdown bit misplaced");

	a_pri_fb_fields: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_PRI_FB) |=> primary_swallow_count == $past(shift_q[6:2])
			&& primary_program_count == $past(shift_q[19:7]) && primary_modulus_sel == $past(shift_q[20])
			&& primary_shutdown_bit == $past(shift_q[21]))
		else $error("primary feedback fields misplaced");

	// ----------------------------------------
	// Assertions: holding
	// ----------------------------------------
	// Shifting alone must leave every latch alone, whatever the bit count
	sequence s_shift_only;
		sclk_rise && !strobe_rise;
	endsequence

	sequence s_quiet_link;
		!sclk_rise && !strobe_rise;
	endsequence

	a_shift_hold: assert property (@(posedge clk) disable iff (!rstn)
		!sclk_rise |=> $stable(shift_q))
		else $error("holding register moved without a serial clock rise");

	a_hold_sec_ref_addr: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_SEC_REF) |=> $stable(sec_fb_q) && $stable(pri_ref_q) && $stable(pri_fb_q))
		else $error("unaddressed latch changed on secondary reference load");

	a_hold_sec_fb_addr: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_SEC_FB) |=> $stable(sec_ref_q) && $stable(pri_ref_q) && $stable(pri_fb_q))
		else $error("unaddressed latch changed on secondary feedback load");

	a_hold_pri_ref_addr: assert property (@(posedge clk) disable iff (!rstn)
		s_strobe_to(ADDR_PRI_REF) |=> $stable(sec_ref_q) && $stable(sec_fb_q) && $stable(pri_fb_q))
		else $error("unaddressed latch changed on primary reference load");

	a_hold_shift_only: assert property (@(posedge clk) disable iff (!rstn)
		s_shift_only |=> $stable(sec_ref_q) && $stable(sec_fb_q) && $stable(pri_ref_q) && $stable(pri_fb_q))
		else $error("latch changed while only shifting");

	a_hold_outputs: assert property (@(posedge clk) disable iff (!rstn)
		s_quiet_link |=> $stable(secondary_ref_ratio) && $stable(primary_ref_ratio)
			&& $stable(secondary_program_count) && $stable(primary_program_count))
		else $error("field output moved with the link quiet");

	a_one_latch_only: assert property (@(posedge clk) disable iff (!rstn)
		strobe_rise |=> $onehot0({$changed(sec_ref_q), $changed(sec_fb_q),
			$changed(pri_ref_q), $changed(pri_fb_q)}))
		else $error("one strobe changed more than one latch");

	// Reset clears every store, so a restarted host starts from known words
	a_reset_clears: assert property (@(posedge clk) !rstn |=> shift_q == SHIFT_RESET
		&& sec_ref_q == WORD_RESET && sec_fb_q == WORD_RESET && pri_ref_q == WORD_RESET && pri_fb_q == WORD_RESET)
		else $error("reset left a store loaded");

	// ----------------------------------------
	// Assertions: pin sampling
	// ----------------------------------------
	// Data must reach the shifter at the same age as the clock edge that picks it up
	a_data_aligned: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn) && $past(rstn, 2) |-> data_sync_q == $past(serial_data, 2))
		else $error("data synchroniser out of step with the serial clock");
endmodule

// ===== design/edge_sync.sv
// Two-stage synchroniser with rising-edge detect
`timescale 1ns/1ps
module edge_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic pin,
	output logic level,
	output logic rise
);
	logic meta_q;
	logic sync_q;
	logic last_q;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			meta_q <= 1'h0;
			sync_q <= 1'h0;
			last_q <= 1'h0;
		end else begin
			meta_q <= pin;
			sync_q <= meta_q;
			last_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = sync_q & ~last_q;
endmodule

// ===== design/synth_cfg_pkg.sv
// Constants for the dual-loop divider configuration store
package synth_cfg_pkg;
	// ----------------------------------------
	// Serial word layout
	// ----------------------------------------
	localparam int WORD_W = 22;
	localparam int DATA_W = 20;
	localparam int ADDR_W = 2;
	localparam int DATA_LSB = 2;
	// ----------------------------------------
	// Latch addresses
	// ----------------------------------------
	localparam logic [1:0] ADDR_SEC_REF = 2'h0;
	localparam logic [1:0] ADDR_SEC_FB = 2'h1;
	localparam logic [1:0] ADDR_PRI_REF = 2'h2;
	localparam logic [1:0] ADDR_PRI_FB = 2'h3;
	// ----------------------------------------
	// Reference word fields
	// ----------------------------------------
	localparam int RATIO_W = 15;
	localparam int RATIO_LSB = 0;
	localparam int DET_SENSE_BIT = 15;
	localparam int PUMP_BOOST_BIT = 16;
	localparam int PUMP_FLOAT_BIT = 17;
	localparam int PIN_SEL_LSB = 18;
	localparam int PIN_SEL_W = 2;
	// ----------------------------------------
	// Feedback word fields
	// ----------------------------------------
	localparam int SWALLOW_W = 5;
	localparam int SWALLOW_LSB = 0;
	localparam int PROGRAM_W = 13;
	localparam int PROGRAM_LSB = 5;
	localparam int MODULUS_BIT = 18;
	localparam int SHUTDOWN_BIT = 19;
	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [19:0] WORD_RESET = 20'h00000;
	localparam logic [21:0] SHIFT_RESET = 22'h000000;
endpackage

// ===== test/host_link_model.sv
// Host-side model of the three-wire serial programming link
`timescale 1ns/1ps
module host_link_model (
	input wire logic clk,
	output logic serial_clk,
	output logic serial_data,
	output logic latch_strobe
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b0;
	end

	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Serial clock stands low between frames; 16 + 16 clk gives the 160 ns period
	task automatic send_word(input logic [21:0] word, input bit strobe);
		for (int i = 21; i >= 0; i--) begin
			serial_data = word[i];
			idle(16);
			serial_clk = 1'b1;
			idle(16);
			serial_clk = 1'b0;
		end
		// Released data line shows the inverse so a stale bit is never mistaken for data
		serial_data = ~word[0];
		idle(4);
		if (strobe) begin
			latch_strobe = 1'b1;
			idle(8);
			latch_strobe = 1'b0;
		end
	endtask
endmodule

// ===== test/test_dual_pll_divider_config_regs.sv
// Self-checking bench for the dual-loop divider configuration store
`timescale 1ns/1ps
module test_dual_pll_divider_config_regs;
	import synth_cfg_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	wire logic serial_clk, serial_data, latch_strobe;
	logic [RATIO_W-1:0] secondary_ref_ratio, primary_ref_ratio;
	logic secondary_detector_sense, secondary_pump_boost, secondary_pump_float;
	logic primary_detector_sense, primary_pump_boost, primary_pump_float;
	logic [PIN_SEL_W-1:0] secondary_pin_sel, primary_pin_sel;
	logic [SWALLOW_W-1:0] secondary_swallow_count, primary_swallow_count;
	logic [PROGRAM_W-1:0] secondary_program_count, primary_program_count;
	logic secondary_modulus_sel, secondary_shutdown_bit, primary_modulus_sel, primary_shutdown_bit;
	logic [19:0] exp_q [4] = '{default: WORD_RESET};
	int num_errors = 0;
	int checks = 0;
	integer seed = 54547;

	always #2.5 clk = ~clk;

	host_link_model host_link_model_i (.clk, .serial_clk, .serial_data, .latch_strobe);

	dual_pll_divider_config_regs dual_pll_divider_config_regs_i (.clk, .rstn, .serial_clk, .serial_data,
		.latch_strobe, .secondary_ref_ratio, .secondary_detector_sense, .secondary_pump_boost,
		.secondary_pump_float, .secondary_pin_sel, .primary_ref_ratio, .primary_detector_sense,
		.primary_pump_boost, .primary_pump_float, .primary_pin_sel, .secondary_swallow_count,
		.secondary_program_count, .secondary_modulus_sel, .secondary_shutdown_bit,
		.primary_swallow_count, .primary_program_count, .primary_modulus_sel, .primary_shutdown_bit);

	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task automatic check(input string name, input logic [19:0] want, input logic [19:0] seen);
		checks++;
		if (seen !== want) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, want, seen);
		end
	endtask

	task automatic check_all();
		check("sec_ref", exp_q[0], {secondary_pin_sel, secondary_pump_float, secondary_pump_boost,
			secondary_detector_sense, secondary_ref_ratio});
		check("sec_fb", exp_q[1], {secondary_shutdown_bit, secondary_modulus_sel,
			secondary_program_count, secondary_swallow_count});
		check("pri_ref", exp_q[2], {primary_pin_sel, primary_pump_float, primary_pump_boost,
			primary_detector_sense, primary_ref_ratio});
		check("pri_fb", exp_q[3], {primary_shutdown_bit, primary_modulus_sel,
			primary_program_count, primary_swallow_count});
	endtask

	// Reference ratios are kept in the legal 2..32767 span
	function automatic logic [19:0] rand_word(input logic [1:0] addr);
		logic [19:0] d;
		d = 20'($random(seed));
		if (!addr[0]) d[14:0] = 15'($unsigned($random(seed)) % 32766 + 2);
		return d;
	endfunction

	task automatic load(input logic [1:0] addr, input logic [19:0] data, input bit strobe);
		host_link_model_i.send_word({data, addr}, strobe);
		if (strobe) exp_q[addr] = data;
		repeat (8) @(negedge clk);
		check_all();
	endtask

	task automatic stop_test();
		if (num_errors == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		repeat (4) @(negedge clk);
		check_all();
		for (int a = 0; a < 4; a++) load(2'(a), rand_word(2'(a)), 1'b1);
		load(ADDR_SEC_REF, 20'h00002, 1'b1);
		load(ADDR_PRI_REF, 20'hFFFFF, 1'b1);
		load(ADDR_SEC_FB, 20'hFFFFF, 1'b1);
		load(ADDR_PRI_FB, 20'h00000, 1'b1);
		load(ADDR_PRI_FB, 20'h5A5A5, 1'b0);
		load(ADDR_SEC_REF, 20'hA5A5A, 1'b0);
		for (int n = 0; n < 8; n++) begin
			logic [1:0] addr;
			addr = 2'($random(seed));
			load(addr, rand_word(addr), 1'b1);
		end
		// Mid-run reset must clear every loaded word and leave the link usable
		rstn = 1'b0;
		repeat (4) @(negedge clk);
		rstn = 1'b1;
		exp_q = '{default: WORD_RESET};
		repeat (4) @(negedge clk);
		check_all();
		load(ADDR_PRI_REF, rand_word(ADDR_PRI_REF), 1'b1);
		stop_test();
	end

	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		stop_test();
	end
endmodule
